// File: design/pdm_defs.vh
`ifndef PDM_DEFS_VH
`define PDM_DEFS_VH
// Register addresses (chosen; none printed)
`define PDM_ADDR_MCU_CTRL    4'h0
`define PDM_ADDR_PORT_B_OUTPUT_DATA_OUT   4'h1
`define PDM_ADDR_PORT_B_OUTPUT_DATA_DIR   4'h2
`define PDM_ADDR_PORTD_OUT   4'h3
`define PDM_ADDR_PORTD_DIR   4'h4
`define PDM_ADDR_PORTD_IN    4'h5
`define PDM_ADDR_CLK_CTRL    4'h6
`define PDM_ADDR_MOD_MODE    4'h7
`define PDM_ADDR_PC_MASK     4'h8
`define PDM_ADDR_PC_CTRL     4'h9
`define PDM_ADDR_IRQ_STATUS  4'hA
`define PDM_ADDR_IRQ_MASK    4'hB
`define PDM_ADDR_PORT_B_OUTPUT_DATA_IN    4'hC
// mcu_control fields
`define PDM_MCU_PUD_BIT      4
`define PDM_MCU_VECTOR_TABLE_SELECT_BIT    1
`define PDM_MCU_VECTOR_CHANGE_ENABLE_BIT     0
`define PDM_MCU_WMASK        8'h13
`define PDM_MCU_RESET        8'h00
// clock_module_ctrl fields
`define PDM_CLK_CMM_LO       0
`define PDM_CLK_CMM_HI       1
`define PDM_CLK_EXT_CLOCK_SELECT_BIT    2
`define PDM_CLK_CSS_BIT      3
`define PDM_CLK_WMASK        8'h0F
// Modulator mode value selecting serial interface
`define PDM_MODE_SPI         4'h9
`define PDM_MODE_WMASK       8'h0F
// Pin change control: bit 0 group enable, bits 2:1 ext irq enables
`define PDM_PC_GRP_BIT       0
`define PDM_PC_EXT_IRQ_ZERO_BIT      1
`define PDM_PC_EXT_IRQ_ONE_BIT      2
`define PDM_PC_WMASK         8'h07
// Interrupt status bits
`define PDM_IRQ_PCHG_BIT     0
`define PDM_IRQ_CLKSW_BIT    1
`define PDM_IRQ_WMASK        8'h03
`define PDM_RESET_BYTE       8'h00
`endif

// File: design/pdm_pin_cell.v
`default_nettype none
// One pin: normal port control with alternate overrides applied
module pdm_pin_cell (
  input  wire pull_disable,
  input  wire dir_bit,
  input  wire out_bit,
  input  wire pullup_override_en,
  input  wire pullup_override_val,
  input  wire direction_override_en,
  input  wire direction_override_val,
  input  wire value_override_en,
  input  wire value_override_val,
  input  wire input_enable_override_en,
  input  wire input_enable_override_val,
  output wire pad_out,
  output wire pad_oe_n,
  output wire pad_pullup,
  output wire input_enable
);
  wire eff_dir;
  wire eff_val;
  wire eff_pu;

  assign eff_dir = direction_override_en ? direction_override_val : dir_bit;
  assign eff_val = value_override_en ? value_override_val : out_bit;
  // Pull-up only for an input pin with data bit set; disable bit wins
  assign eff_pu  = pullup_override_en ? pullup_override_val
                 : (~eff_dir & out_bit & ~pull_disable);
  assign pad_out      = eff_val;
  assign pad_oe_n     = ~eff_dir;
  assign pad_pullup   = eff_pu;
  // Sleep gating of inputs lives elsewhere, so the plain enable is one
  assign input_enable = input_enable_override_en ? input_enable_override_val : 1'b1;
endmodule // pdm_pin_cell
`default_nettype wire

// File: design/pdm_port_d_mux.v
`include "pdm_defs.vh"
`default_nettype none
module pdm_port_d_mux #(
  parameter WIDTH = 8
) (
  input  wire             ref_clk,
  input  wire             reset,
  input  wire [3:0]       reg_addr,
  input  wire [7:0]       reg_wdata,
  input  wire             reg_write,
  input  wire             reg_read,
  output reg  [7:0]       reg_rdata,
  input  wire [WIDTH-1:0] port_d_pad_in,
  output wire [WIDTH-1:0] port_d_pad_out,
  output wire [WIDTH-1:0] port_d_pad_oe_n,
  output wire [WIDTH-1:0] port_d_pad_pullup,
  input  wire [WIDTH-1:0] port_b_pad_in,
  output wire [WIDTH-1:0] port_b_pad_out,
  output wire [WIDTH-1:0] port_b_pad_oe_n,
  output wire [WIDTH-1:0] port_b_pad_pullup,
  input  wire             modulator_output_one,
  input  wire             modulator_output_one_en,
  input  wire             modulator_output_two,
  input  wire             modulator_output_two_en,
  input  wire             ext_clock_pin_zero,
  output reg              ext_clock_out,
  output reg              ext_clock_active,
  output reg              serial_in_pin,
  output reg              ext_irq_zero,
  output reg              ext_irq_one,
  output reg              timer_ext_clock_in,
  output reg              capture_input_pin,
  output reg  [WIDTH-1:0] pin_change_src,
  output reg              vector_table_select,
  output reg              vector_change_enable,
  output wire             irq
);
  // ==========================================================
  // Registers
  reg  [7:0]       mcu_control;
  reg  [7:0]       port_b_output_data;
  reg  [7:0]       port_b_direction;
  reg  [7:0]       port_d_out;
  reg  [7:0]       port_d_dir;
  reg  [7:0]       clock_module_ctrl;
  reg  [7:0]       modulator_mode_reg_b;
  reg  [7:0]       pc_mask;
  reg  [7:0]       pc_ctrl;
  reg  [7:0]       irq_status;
  reg  [7:0]       irq_mask;
  reg  [WIDTH-1:0] d_sync1;
  reg  [WIDTH-1:0] d_sync2;
  reg  [WIDTH-1:0] d_prev;
  reg  [WIDTH-1:0] b_sync1;
  reg  [WIDTH-1:0] b_sync2;
  reg              clk_sel_prev;
  reg  [7:0]       next_rdata;
  wire [WIDTH-1:0] d_in_en;
  wire [WIDTH-1:0] b_in_en;
  wire [WIDTH-1:0] d_direction_override_en;
  wire [WIDTH-1:0] d_value_override_en;
  wire [WIDTH-1:0] d_pvov;
  wire [WIDTH-1:0] d_input_enable_override_en;
  wire [WIDTH-1:0] d_gated;
  wire [WIDTH-1:0] d_readback;
  wire [WIDTH-1:0] d_out_view;
  wire [WIDTH-1:0] d_dir_view;
  wire [WIDTH-1:0] pc_event;
  wire             pullup_disable;
  wire             spi_mode;
  wire             clk_pd4;
  wire             clk_pc0;

  // ==========================================================
  // Override terms
  assign pullup_disable      = mcu_control[`PDM_MCU_PUD_BIT];
  assign spi_mode = (modulator_mode_reg_b[3:0] == `PDM_MODE_SPI);
  assign clk_pd4  = clock_module_ctrl[`PDM_CLK_CMM_HI] & clock_module_ctrl[`PDM_CLK_CMM_LO]
                  & clock_module_ctrl[`PDM_CLK_EXT_CLOCK_SELECT_BIT]
                  & clock_module_ctrl[`PDM_CLK_CSS_BIT];
  assign clk_pc0  = clock_module_ctrl[`PDM_CLK_CMM_HI] & clock_module_ctrl[`PDM_CLK_CMM_LO]
                  & ~clock_module_ctrl[`PDM_CLK_EXT_CLOCK_SELECT_BIT]
                  & clock_module_ctrl[`PDM_CLK_CSS_BIT];

  // Pin 7 forced input; pull-up stays on the normal path via data bit 7
  assign d_direction_override_en = {spi_mode, 3'b000, clk_pd4, 3'b000};
  assign d_value_override_en = {1'b0, modulator_output_two_en, modulator_output_one_en, 5'b00000};
  assign d_pvov = {1'b0, modulator_output_two, modulator_output_one, 5'b00000};
  assign d_input_enable_override_en = (pc_mask & {WIDTH{pc_ctrl[`PDM_PC_GRP_BIT]}})
                 | {4'b0000, pc_ctrl[`PDM_PC_EXT_IRQ_ONE_BIT], pc_ctrl[`PDM_PC_EXT_IRQ_ZERO_BIT], 2'b00};

  // Clock pin hides its data and direction bits from I/O use
  assign d_out_view = port_d_out & ~{3'b000, clk_pd4, 4'b0000};
  assign d_dir_view = port_d_dir & ~{3'b000, clk_pd4, 4'b0000};

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
      pdm_pin_cell u_d (
        .pull_disable              (pullup_disable),
        .dir_bit                   (d_dir_view[i]),
        .out_bit                   (d_out_view[i]),
        .pullup_override_en        (1'b0),
        .pullup_override_val       (1'b0),
        .direction_override_en     (d_direction_override_en[i]),
        .direction_override_val    (1'b0),
        .value_override_en         (d_value_override_en[i]),
        .value_override_val        (d_pvov[i]),
        .input_enable_override_en  (d_input_enable_override_en[i]),
        .input_enable_override_val (1'b1),
        .pad_out                   (port_d_pad_out[i]),
        .pad_oe_n                  (port_d_pad_oe_n[i]),
        .pad_pullup                (port_d_pad_pullup[i]),
        .input_enable              (d_in_en[i])
      );
      pdm_pin_cell u_b (
        .pull_disable              (pullup_disable),
        .dir_bit                   (port_b_direction[i]),
        .out_bit                   (port_b_output_data[i]),
        .pullup_override_en        (1'b0),
        .pullup_override_val       (1'b0),
        .direction_override_en     (1'b0),
        .direction_override_val    (1'b0),
        .value_override_en         (1'b0),
        .value_override_val        (1'b0),
        .input_enable_override_en  (1'b0),
        .input_enable_override_val (1'b0),
        .pad_out                   (port_b_pad_out[i]),
        .pad_oe_n                  (port_b_pad_oe_n[i]),
        .pad_pullup                (port_b_pad_pullup[i]),
        .input_enable              (b_in_en[i])
      );
    end
  endgenerate

  assign d_gated    = d_sync2 & d_in_en;
  assign d_readback = d_gated & ~{3'b000, clk_pd4, 4'b0000};
  assign pc_event   = (d_gated ^ d_prev) & pc_mask & {WIDTH{pc_ctrl[`PDM_PC_GRP_BIT]}};
  assign irq        = |(irq_status & irq_mask);

  // ==========================================================
  // Pin sampling and alternate inputs
  always @(posedge ref_clk) begin
    if (reset) begin
      d_sync1            <= {WIDTH{1'b0}};
      d_sync2            <= {WIDTH{1'b0}};
      d_prev             <= {WIDTH{1'b0}};
      b_sync1            <= {WIDTH{1'b0}};
      b_sync2            <= {WIDTH{1'b0}};
      serial_in_pin      <= 1'b0;
      ext_irq_zero       <= 1'b0;
      ext_irq_one        <= 1'b0;
      timer_ext_clock_in <= 1'b0;
      capture_input_pin  <= 1'b0;
      pin_change_src     <= {WIDTH{1'b0}};
      ext_clock_out      <= 1'b0;
      ext_clock_active   <= 1'b0;
      clk_sel_prev       <= 1'b0;
    end else begin
      d_sync1            <= port_d_pad_in;
      d_sync2            <= d_sync1;
      d_prev             <= d_gated;
      b_sync1            <= port_b_pad_in;
      b_sync2            <= b_sync1;
      serial_in_pin      <= d_gated[7];
      ext_irq_one        <= d_gated[3];
      ext_irq_zero       <= d_gated[2];
      timer_ext_clock_in <= d_gated[1];
      capture_input_pin  <= d_gated[0];
      pin_change_src     <= pc_event;
      // Sampled clocks are only fit for slow external clocks
      ext_clock_out      <= clk_pd4 ? d_sync2[4] : (clk_pc0 ? ext_clock_pin_zero : 1'b0);
      ext_clock_active   <= clk_pd4 | clk_pc0;
      clk_sel_prev       <= clk_pd4 | clk_pc0;
    end
  end

  // ==========================================================
  // Register writes and interrupt status
  always @(posedge ref_clk) begin
    if (reset) begin
      mcu_control          <= `PDM_MCU_RESET;
      port_b_output_data   <= `PDM_RESET_BYTE;
      port_b_direction     <= `PDM_RESET_BYTE;
      port_d_out           <= `PDM_RESET_BYTE;
      port_d_dir           <= `PDM_RESET_BYTE;
      clock_module_ctrl    <= `PDM_RESET_BYTE;
      modulator_mode_reg_b <= `PDM_RESET_BYTE;
      pc_mask              <= `PDM_RESET_BYTE;
      pc_ctrl              <= `PDM_RESET_BYTE;
      irq_status           <= `PDM_RESET_BYTE;
      irq_mask             <= `PDM_RESET_BYTE;
      vector_table_select  <= 1'b0;
      vector_change_enable <= 1'b0;
    end else begin
      if (reg_write) begin
        case (reg_addr)
          `PDM_ADDR_MCU_CTRL:   mcu_control <= reg_wdata & `PDM_MCU_WMASK;
          `PDM_ADDR_PORT_B_OUTPUT_DATA_OUT:  port_b_output_data <= reg_wdata;
          `PDM_ADDR_PORT_B_OUTPUT_DATA_DIR:  port_b_direction <= reg_wdata;
          `PDM_ADDR_PORTD_OUT:  port_d_out <= reg_wdata;
          `PDM_ADDR_PORTD_DIR:  port_d_dir <= reg_wdata;
          `PDM_ADDR_CLK_CTRL:   clock_module_ctrl <= reg_wdata & `PDM_CLK_WMASK;
          `PDM_ADDR_MOD_MODE:   modulator_mode_reg_b <= reg_wdata & `PDM_MODE_WMASK;
          `PDM_ADDR_PC_MASK:    pc_mask <= reg_wdata;
          `PDM_ADDR_PC_CTRL:    pc_ctrl <= reg_wdata & `PDM_PC_WMASK;
          `PDM_ADDR_IRQ_MASK:   irq_mask <= reg_wdata & `PDM_IRQ_WMASK;
          default: ;
        endcase
      end
      vector_table_select  <= mcu_control[`PDM_MCU_VECTOR_TABLE_SELECT_BIT];
      vector_change_enable <= mcu_control[`PDM_MCU_VECTOR_CHANGE_ENABLE_BIT];
      // Read clears status; a new event in the same cycle wins
      irq_status <= ((reg_read && reg_addr == `PDM_ADDR_IRQ_STATUS) ? 8'h00 : irq_status)
                  | {6'b000000, (clk_pd4 | clk_pc0) ^ clk_sel_prev, |pc_event};
    end
  end

  // ==========================================================
  // Read data, valid in the cycle after the strobe
  always @* begin
    case (reg_addr)
      `PDM_ADDR_MCU_CTRL:   next_rdata = mcu_control;
      `PDM_ADDR_PORT_B_OUTPUT_DATA_OUT:  next_rdata = port_b_output_data;
      `PDM_ADDR_PORT_B_OUTPUT_DATA_DIR:  next_rdata = port_b_direction;
      `PDM_ADDR_PORTD_OUT:  next_rdata = d_out_view;
      `PDM_ADDR_PORTD_DIR:  next_rdata = d_dir_view;
      `PDM_ADDR_PORTD_IN:   next_rdata = d_readback;
      `PDM_ADDR_CLK_CTRL:   next_rdata = clock_module_ctrl;
      `PDM_ADDR_MOD_MODE:   next_rdata = modulator_mode_reg_b;
      `PDM_ADDR_PC_MASK:    next_rdata = pc_mask;
      `PDM_ADDR_PC_CTRL:    next_rdata = pc_ctrl;
      `PDM_ADDR_IRQ_STATUS: next_rdata = irq_status;
      `PDM_ADDR_IRQ_MASK:   next_rdata = irq_mask;
      `PDM_ADDR_PORT_B_OUTPUT_DATA_IN:   next_rdata = b_sync2 & b_in_en;
      default:              next_rdata = 8'h00;
    endcase
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_read ? next_rdata : 8'h00;
    end
  end
endmodule // pdm_port_d_mux
`default_nettype wire

// File: dv/pdm_port_d_mux_assertions.sv
`include "pdm_defs.vh"
`default_nettype none
module pdm_port_d_mux_assertions #(
  parameter WIDTH = 8
) (
  input wire logic             ref_clk,
  input wire logic             reset,
  input wire logic [3:0]       reg_addr,
  input wire logic [7:0]       reg_wdata,
  input wire logic             reg_write,
  input wire logic             reg_read,
  input wire logic [7:0]       reg_rdata,
  input wire logic [WIDTH-1:0] port_d_pad_out,
  input wire logic [WIDTH-1:0] port_d_pad_oe_n,
  input wire logic [WIDTH-1:0] port_d_pad_pullup,
  input wire logic [WIDTH-1:0] port_b_pad_pullup,
  input wire logic             modulator_output_one,
  input wire logic             modulator_output_one_en,
  input wire logic             modulator_output_two,
  input wire logic             modulator_output_two_en
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Shadow of the control registers, rebuilt from the write port
  logic [7:0] s_mcu, s_out, s_dir, s_clk, s_mode;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      {s_mcu, s_out, s_dir, s_clk, s_mode} <= 40'h0;
    end else if (reg_write) begin
      case (reg_addr)
        `PDM_ADDR_MCU_CTRL:  s_mcu <= reg_wdata & `PDM_MCU_WMASK;
        `PDM_ADDR_PORTD_OUT: s_out <= reg_wdata;
        `PDM_ADDR_PORTD_DIR: s_dir <= reg_wdata;
        `PDM_ADDR_CLK_CTRL:  s_clk <= reg_wdata & `PDM_CLK_WMASK;
        `PDM_ADDR_MOD_MODE:  s_mode <= reg_wdata & `PDM_MODE_WMASK;
        default: ;
      endcase
    end
  end
  // ==========================================================
  // Properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  serial_force_in_a: assert property (s_mode[3:0] == `PDM_MODE_SPI |-> port_d_pad_oe_n[7])
    else $error("pin 7 driven in serial mode");
  serial_pullup_a: assert property (s_mode[3:0] == `PDM_MODE_SPI |->
    port_d_pad_pullup[7] == (s_out[7] & ~s_mcu[`PDM_MCU_PUD_BIT])) else $error("pin 7 pull-up");
  mod_two_drive_a: assert property (modulator_output_two_en && s_dir[6] |->
    port_d_pad_out[6] == modulator_output_two && !port_d_pad_oe_n[6]) else $error("pin 6 mod");
  gpio_six_a: assert property (!modulator_output_two_en && s_dir[6] |->
    port_d_pad_out[6] == s_out[6]) else $error("pin 6 not plain output");
  mod_one_drive_a: assert property (modulator_output_one_en && s_dir[5] |->
    port_d_pad_out[5] == modulator_output_one && !port_d_pad_oe_n[5]) else $error("pin 5 mod");
  clock_pin_in_a: assert property (s_clk[3:0] == 4'hF |-> port_d_pad_oe_n[4])
    else $error("pin 4 driven while clock input");
  clock_read_zero_a: assert property (reg_read && s_clk[3:0] == 4'hF &&
    reg_addr inside {`PDM_ADDR_PORTD_OUT, `PDM_ADDR_PORTD_DIR, `PDM_ADDR_PORTD_IN}
    |=> reg_rdata[4] == 1'b0) else $error("pin 4 bit reads nonzero");
  pullup_off_a: assert property (s_mcu[`PDM_MCU_PUD_BIT] |->
    port_d_pad_pullup == 8'h00 && port_b_pad_pullup == 8'h00) else $error("pull-up on");
  low_pins_gpio_a: assert property (port_d_pad_oe_n[3:0] == ~s_dir[3:0])
    else $error("pins 3..0 direction wrong");
  cover property (s_mode[3:0] == `PDM_MODE_SPI);
  cover property (s_clk[3:0] == 4'hF && reg_read);
  cover property (modulator_output_two_en && s_dir[6]);
endmodule // pdm_port_d_mux_assertions
`default_nettype wire

// File: dv/pdm_pin_world.sv
`default_nettype none
module pdm_pin_world (
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe_n,
  input  wire logic [7:0] pad_pullup,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_lvl,
  output var  logic [7:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Board has weak pull-downs: an undriven pin reads low unless pulled up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_lvl[i];
      else pad_in[i] = pad_pullup[i];
    end
  end
endmodule // pdm_pin_world
`default_nettype wire

// File: dv/tb_pdm_port_d_mux.sv
`include "pdm_defs.vh"
`default_nettype none
module tb_pdm_port_d_mux;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk, reset, reg_write, reg_read, m1, m1_en, m2, m2_en, ecp0;
  logic       eco, eca, sdi, i0, i1, tci, cap, vts, vce, irq;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, pd_in, pd_out, pd_oe_n, pd_pu, pc_src, acc;
  logic [7:0] pb_in, pb_out, pb_oe_n, pb_pu, ext_en, ext_lvl;
  logic [3:0] ra [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB};
  int         miscompares, checked, n;
  pdm_port_d_mux #(.WIDTH(8)) pdm_port_d_mux_i (.ref_clk(ref_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .port_d_pad_in(pd_in), .port_d_pad_out(pd_out),
    .port_d_pad_oe_n(pd_oe_n), .port_d_pad_pullup(pd_pu), .port_b_pad_in(pb_in),
    .port_b_pad_out(pb_out), .port_b_pad_oe_n(pb_oe_n), .port_b_pad_pullup(pb_pu),
    .modulator_output_one(m1), .modulator_output_one_en(m1_en), .modulator_output_two(m2),
    .modulator_output_two_en(m2_en), .ext_clock_pin_zero(ecp0), .ext_clock_out(eco),
    .ext_clock_active(eca), .serial_in_pin(sdi), .ext_irq_zero(i0), .ext_irq_one(i1),
    .timer_ext_clock_in(tci), .capture_input_pin(cap), .pin_change_src(pc_src),
    .vector_table_select(vts), .vector_change_enable(vce), .irq(irq));
  pdm_pin_world pdm_pin_world_i (.pad_out(pd_out), .pad_oe_n(pd_oe_n), .pad_pullup(pd_pu),
    .ext_en(ext_en), .ext_lvl(ext_lvl), .pad_in(pd_in));
  // ==========================================================
  // Access and compare tasks
  task automatic chk(input logic [7:0] act, input logic [7:0] exp);
    checked++;
    if (act !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h want %h", $time, act, exp);
    end
  endtask
  // Strobe dropped and one edge let pass, so the next call never double-drives it
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, exp);
    @(posedge ref_clk);
  endtask
  task automatic tally_and_finish;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // Clock, watchdog, tests
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    #20000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    {reg_write, reg_read, m1, m1_en, m2, m2_en, ecp0} = 7'h00;
    reset = 1'b1;
    reg_addr = 4'h0;
    {reg_wdata, ext_en, ext_lvl} = 24'h0;
    pb_in = 8'hA5;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    foreach (ra[i]) rd(ra[i], 8'h00);
    wr(`PDM_ADDR_MCU_CTRL, 8'hFF);
    rd(`PDM_ADDR_MCU_CTRL, 8'h13);
    chk({6'h00, vts, vce}, 8'h03);
    wr(4'hD, 8'hFF);
    rd(4'hD, 8'h00);
    rd(`PDM_ADDR_PORT_B_OUTPUT_DATA_IN, 8'hA5);
    wr(`PDM_ADDR_PORT_B_OUTPUT_DATA_OUT, 8'h5A);
    wr(`PDM_ADDR_PORT_B_OUTPUT_DATA_DIR, 8'hC3);
    rd(`PDM_ADDR_PORT_B_OUTPUT_DATA_DIR, 8'hC3);
    chk(pb_oe_n, 8'h3C);
    chk(pb_out, 8'h5A);
    wr(`PDM_ADDR_PORTD_OUT, 8'hFF);
    chk(pd_pu | pb_pu, 8'h00);
    wr(`PDM_ADDR_MCU_CTRL, 8'h00);
    chk(pd_pu, 8'hFF);
    chk(pb_pu, 8'h18);
    wr(`PDM_ADDR_PORTD_DIR, 8'hFF);
    wr(`PDM_ADDR_PORTD_OUT, 8'h80);
    wr(`PDM_ADDR_MOD_MODE, 8'h09);
    chk(pd_oe_n, 8'h80);
    chk(pd_pu, 8'h80);
    repeat (4) @(posedge ref_clk);
    chk({7'h00, sdi}, 8'h01);
    wr(`PDM_ADDR_MOD_MODE, 8'h08);
    chk(pd_oe_n, 8'h00);
    wr(`PDM_ADDR_PORTD_OUT, 8'h00);
    wr(`PDM_ADDR_PORTD_DIR, 8'h60);
    {m2_en, m2, m1_en, m1} <= 4'hE;
    @(posedge ref_clk);
    chk(pd_out & 8'h60, 8'h40);
    chk(pd_oe_n & 8'h60, 8'h00);
    {m2_en, m1_en} <= 2'b00;
    wr(`PDM_ADDR_PORTD_OUT, 8'h20);
    chk(pd_out & 8'h60, 8'h20);
    wr(`PDM_ADDR_PORTD_OUT, 8'h00);
    wr(`PDM_ADDR_PORTD_DIR, 8'h00);
    ext_en <= 8'hFF;
    wr(`PDM_ADDR_PC_MASK, 8'h04);
    wr(`PDM_ADDR_PC_CTRL, 8'h01);
    wr(`PDM_ADDR_IRQ_MASK, 8'h01);
    rd(`PDM_ADDR_IRQ_STATUS, 8'h00);
    ext_lvl <= 8'h04;
    n = 0;
    while (pc_src !== 8'h04 && n < 10) begin
      @(posedge ref_clk);
      n++;
    end
    chk(pc_src, 8'h04);
    @(posedge ref_clk);
    chk({7'h00, irq}, 8'h01);
    rd(`PDM_ADDR_IRQ_STATUS, 8'h01);
    chk({7'h00, irq}, 8'h00);
    ext_lvl <= 8'h0F;
    acc = 8'h00;
    repeat (6) begin
      @(posedge ref_clk);
      acc = acc | pc_src;
    end
    chk(acc, 8'h00);
    chk({4'h0, i1, i0, tci, cap}, 8'h0F);
    // Pin 2 falls when the far side lets go, so its change source is masked first
    wr(`PDM_ADDR_PC_MASK, 8'h00);
    ext_en <= 8'h00;
    wr(`PDM_ADDR_PORTD_DIR, 8'h10);
    wr(`PDM_ADDR_PORTD_OUT, 8'h10);
    wr(`PDM_ADDR_IRQ_MASK, 8'h02);
    wr(`PDM_ADDR_CLK_CTRL, 8'h0F);
    chk(pd_oe_n & 8'h10, 8'h10);
    ext_en <= 8'h10;
    ext_lvl <= 8'h10;
    rd(`PDM_ADDR_PORTD_OUT, 8'h00);
    rd(`PDM_ADDR_PORTD_DIR, 8'h00);
    repeat (3) @(posedge ref_clk);
    rd(`PDM_ADDR_PORTD_IN, 8'h00);
    chk({6'h00, eca, eco}, 8'h03);
    chk({7'h00, irq}, 8'h01);
    rd(`PDM_ADDR_IRQ_STATUS, 8'h02);
    chk({7'h00, irq}, 8'h00);
    wr(`PDM_ADDR_CLK_CTRL, 8'h0B);
    ecp0 <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk({6'h00, eca, eco}, 8'h03);
    chk(pd_oe_n & 8'h10, 8'h00);
    ecp0 <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk({7'h00, eco}, 8'h00);
    tally_and_finish();
  end
endmodule // tb_pdm_port_d_mux
bind pdm_port_d_mux pdm_port_d_mux_assertions #(.WIDTH(WIDTH)) pdm_port_d_mux_assertions_i (
  .ref_clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .port_d_pad_out,
  .port_d_pad_oe_n, .port_d_pad_pullup, .port_b_pad_pullup, .modulator_output_one,
  .modulator_output_one_en, .modulator_output_two, .modulator_output_two_en);
`default_nettype wire
